//--- ssc_consts.svh
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH
// ==========================================================
// Register offsets
`define SSC_OFF_BUF 16'h078C
`define SSC_OFF_ADDR 16'h078D
`define SSC_OFF_STAT 16'h078F
`define SSC_OFF_CTRL1 16'h0790
`define SSC_OFF_SEQ 16'h0791
`define SSC_OFF_EVT 16'h0792
// ==========================================================
// Field positions
`define SSC_C1_OVF 6
`define SSC_C1_EN 5
`define SSC_C1_REL 4
`define SSC_SQ_GC 7
`define SSC_SQ_ACKST 6
`define SSC_SQ_ACK_VALUE_TO_SEND 5
`define SSC_SQ_ACK_SEQUENCE_TRIGGER 4
`define SSC_SQ_HOST_RECEIVE_ENABLE 3
`define SSC_SQ_STOP 2
`define SSC_SQ_RST 1
`define SSC_SQ_START 0
`define SSC_EV_ACKT 7
`define SSC_EV_PIE 6
`define SSC_EV_SIE 5
`define SSC_EV_ADDRESS_HOLD_ENABLE 1
`define SSC_EV_DATA_HOLD_ENABLE 0
// ==========================================================
// Reset values
`define SSC_RST_REG 8'h00
`endif

//--- ssc_pkg.sv
package ssc_pkg;
  typedef enum logic [3:0] {
    SSC_SPI_D4 = 4'h0, SSC_SPI_D16 = 4'h1, SSC_SPI_D64 = 4'h2,
    SSC_SPI_TMR = 4'h3, SSC_SPI_CS = 4'h4, SSC_SPI_NOCS = 4'h5,
    SSC_I2C_C7 = 4'h6, SSC_I2C_C10 = 4'h7, SSC_I2C_HOST = 4'h8,
    SSC_RSV9 = 4'h9, SSC_SPI_BAUD = 4'hA, SSC_I2C_FW = 4'hB,
    SSC_RSVC = 4'hC, SSC_RSVD = 4'hD, SSC_I2C_C7I = 4'hE,
    SSC_I2C_C10I = 4'hF
  } ssc_mode_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } ssc_wire_t;
endpackage

//--- ssc_core.sv
`timescale 1ns/1ps
`include "ssc_consts.svh"
module ssc_core #(
  parameter int unsigned OSC_HZ = 100_000_000
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic periodic_timer_output_i,
  input wire logic serial_clock_pin_i,
  input wire logic client_select_pin_n_i,
  input wire ssc_pkg::ssc_wire_t bus_i,
  output ssc_pkg::ssc_wire_t bus_o,
  output ssc_pkg::ssc_wire_t bus_oe_n_o,
  output logic port_pins_owned_o,
  output logic spi_clk_o,
  output logic start_event_o,
  output logic stop_event_o
);
  // ==========================================================
  // Registers
  logic [7:0] shift_buffer;
  logic [7:0] baud_or_address_value;
  logic [7:0] shreg;
  logic [3:0] port_mode_select;
  logic port_enable, clock_release, overflow;
  logic general_call_enable, ack_received_status, ack_value_to_send;
  logic ack_sequence_trigger, host_receive_enable, stop_trigger;
  logic repeated_start_trigger, start_trigger, buf_full;
  logic ack_window_flag, stop_irq_enable, start_irq_enable;
  logic address_hold_enable, data_hold_enable;
  logic tx_busy;
  ssc_pkg::ssc_mode_t mode;
  assign mode = ssc_pkg::ssc_mode_t'(port_mode_select);

  logic is_host, is_client, is_spi, active;
  always_comb begin
    is_host = mode == ssc_pkg::SSC_I2C_HOST || mode == ssc_pkg::SSC_I2C_FW;
    is_client = mode == ssc_pkg::SSC_I2C_C7 || mode == ssc_pkg::SSC_I2C_C10 ||
                mode == ssc_pkg::SSC_I2C_C7I || mode == ssc_pkg::SSC_I2C_C10I;
    is_spi = !is_host && !is_client;
  end
  assign active = start_trigger && is_host || repeated_start_trigger ||
                  stop_trigger || ack_sequence_trigger ||
                  host_receive_enable || tx_busy;

  // ==========================================================
  // Baud tick: quarter-period of the bus clock
  logic [7:0] bcnt;
  logic qtick;
  assign qtick = bcnt == 8'h00;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bcnt <= 8'h00;
    end else if (!port_enable || qtick) begin
      bcnt <= baud_or_address_value;
    end else begin
      bcnt <= bcnt - 8'h01;
    end
  end

  // ==========================================================
  // SPI clock generation: internal host rates and external client clock
  logic [5:0] pdiv;
  logic tmr_q, tmr_half;
  logic [7:0] spi_cnt;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pdiv <= 6'h00;
      tmr_q <= 1'b0;
      tmr_half <= 1'b0;
    end else begin
      pdiv <= pdiv + 6'h01;
      tmr_q <= periodic_timer_output_i;
      if (periodic_timer_output_i && !tmr_q) begin
        tmr_half <= !tmr_half;
      end
    end
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      spi_clk_o <= 1'b0;
      spi_cnt <= 8'h00;
    end else if (!port_enable) begin
      spi_clk_o <= 1'b0;
    end else begin
      unique case (mode)
        ssc_pkg::SSC_SPI_D4: spi_clk_o <= pdiv[1];
        ssc_pkg::SSC_SPI_D16: spi_clk_o <= pdiv[3];
        ssc_pkg::SSC_SPI_D64: spi_clk_o <= pdiv[5];
        ssc_pkg::SSC_SPI_TMR: spi_clk_o <= tmr_half;
        ssc_pkg::SSC_SPI_BAUD: begin
          // Toggle every 2*(baud+1) clocks
          if (spi_cnt == {baud_or_address_value[6:0], 1'b1}) begin
            spi_cnt <= 8'h00;
            spi_clk_o <= !spi_clk_o;
          end else begin
            spi_cnt <= spi_cnt + 8'h01;
          end
        end
        ssc_pkg::SSC_SPI_CS: begin
          // Select pin gates the external clock
          spi_clk_o <= serial_clock_pin_i && !client_select_pin_n_i;
        end
        ssc_pkg::SSC_SPI_NOCS: spi_clk_o <= serial_clock_pin_i;
        default: spi_clk_o <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Host sequencer
  typedef enum logic [2:0] {
    SQ_IDLE, SQ_START, SQ_RSTART, SQ_STOP, SQ_BIT
  } sq_t;
  sq_t sq;
  logic [1:0] ph;
  logic [3:0] bitn;
  logic seq_done, byte_done;
  logic scl_drv, sda_drv;
  logic bit_rx;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sq <= SQ_IDLE;
      ph <= 2'd0;
      bitn <= 4'd0;
      scl_drv <= 1'b1;
      sda_drv <= 1'b1;
      seq_done <= 1'b0;
      byte_done <= 1'b0;
      bit_rx <= 1'b0;
    end else begin
      seq_done <= 1'b0;
      byte_done <= 1'b0;
      if (!port_enable || !is_host) begin
        sq <= SQ_IDLE;
        scl_drv <= 1'b1;
        sda_drv <= 1'b1;
      end else if (qtick) begin
        ph <= ph + 2'd1;
        unique case (sq)
          SQ_IDLE: begin
            ph <= 2'd0;
            if (start_trigger) begin
              sq <= SQ_START;
            end else if (repeated_start_trigger) begin
              sq <= SQ_RSTART;
            end else if (stop_trigger) begin
              sq <= SQ_STOP;
            end else if (ack_sequence_trigger || host_receive_enable ||
                         tx_busy) begin
              sq <= SQ_BIT;
              bitn <= ack_sequence_trigger ? 4'd8 : 4'd0;
            end
          end
          SQ_START: begin
            // Data falls while clock high
            if (ph == 2'd1) sda_drv <= 1'b0;
            if (ph == 2'd3) begin
              scl_drv <= 1'b0;
              sq <= SQ_IDLE;
              seq_done <= 1'b1;
            end
          end
          SQ_RSTART: begin
            if (ph == 2'd0) sda_drv <= 1'b1;
            if (ph == 2'd1) scl_drv <= 1'b1;
            if (ph == 2'd2) sda_drv <= 1'b0;
            if (ph == 2'd3) begin
              scl_drv <= 1'b0;
              sq <= SQ_IDLE;
              seq_done <= 1'b1;
            end
          end
          SQ_STOP: begin
            if (ph == 2'd0) sda_drv <= 1'b0;
            if (ph == 2'd1) scl_drv <= 1'b1;
            if (ph == 2'd2) sda_drv <= 1'b1;
            if (ph == 2'd3) begin
              sq <= SQ_IDLE;
              seq_done <= 1'b1;
            end
          end
          SQ_BIT: begin
            if (ph == 2'd0) begin
              // Data changes with clock low
              if (bitn == 4'd8) begin
                sda_drv <= ack_sequence_trigger ? ack_value_to_send : 1'b1;
              end else begin
                sda_drv <= tx_busy ? shreg[7] : 1'b1;
              end
            end
            if (ph == 2'd1) scl_drv <= 1'b1;
            if (ph == 2'd2) bit_rx <= bus_i.sda;
            if (ph == 2'd3) begin
              scl_drv <= 1'b0;
              if (bitn == 4'd8 || (host_receive_enable && bitn == 4'd7)) begin
                sq <= SQ_IDLE;
                seq_done <= 1'b1;
                byte_done <= 1'b1;
              end
              bitn <= bitn + 4'd1;
            end
          end
          default: sq <= SQ_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Shift register and buffer
  logic buf_wr;
  assign buf_wr = wr_i && addr_i == `SSC_OFF_BUF && !active;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shreg <= `SSC_RST_REG;
      shift_buffer <= `SSC_RST_REG;
      tx_busy <= 1'b0;
      buf_full <= 1'b0;
      ack_received_status <= 1'b0;
    end else begin
      if (buf_wr) begin
        shreg <= wdata_i;
        shift_buffer <= wdata_i;
        tx_busy <= is_host && port_enable;
        buf_full <= 1'b1;
      end else if (rd_i && addr_i == `SSC_OFF_BUF) begin
        buf_full <= 1'b0;
      end
      if (sq == SQ_BIT && qtick && ph == 2'd3) begin
        if (bitn < 4'd8) begin
          shreg <= {shreg[6:0], bit_rx};
        end
        if (host_receive_enable && bitn == 4'd7) begin
          shift_buffer <= {shreg[6:0], bit_rx};
          buf_full <= 1'b1;
        end
        if (tx_busy && bitn == 4'd8) begin
          ack_received_status <= bit_rx;
          tx_busy <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Client edge tracking
  logic scl_q, sda_q, scl_rise, scl_fall;
  logic [3:0] cbit;
  assign scl_rise = bus_i.scl && !scl_q;
  assign scl_fall = !bus_i.scl && scl_q;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cbit <= 4'd0;
      start_event_o <= 1'b0;
      stop_event_o <= 1'b0;
    end else begin
      scl_q <= bus_i.scl;
      sda_q <= bus_i.sda;
      start_event_o <= 1'b0;
      stop_event_o <= 1'b0;
      if (port_enable && !is_spi && bus_i.scl && sda_q && !bus_i.sda) begin
        cbit <= 4'd0;
        start_event_o <= mode == ssc_pkg::SSC_I2C_C7I ||
          mode == ssc_pkg::SSC_I2C_C10I || start_irq_enable;
      end else if (port_enable && !is_spi && bus_i.scl && !sda_q &&
                   bus_i.sda) begin
        stop_event_o <= mode == ssc_pkg::SSC_I2C_C7I ||
          mode == ssc_pkg::SSC_I2C_C10I || stop_irq_enable;
      end else if (scl_fall && is_client) begin
        cbit <= (cbit == 4'd8) ? 4'd0 : cbit + 4'd1;
      end
    end
  end

  // ==========================================================
  // Register writes
  logic seq_wr, evt_wr, c1_wr;
  logic hold_on, eighth_fall;
  assign seq_wr = wr_i && addr_i == `SSC_OFF_SEQ;
  assign evt_wr = wr_i && addr_i == `SSC_OFF_EVT;
  assign c1_wr = wr_i && addr_i == `SSC_OFF_CTRL1;
  assign hold_on = is_client && (address_hold_enable || data_hold_enable);
  assign eighth_fall = scl_fall && cbit == 4'd7;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_mode_select <= 4'h0;
      port_enable <= 1'b0;
      clock_release <= 1'b0;
      overflow <= 1'b0;
      baud_or_address_value <= `SSC_RST_REG;
    end else begin
      if (c1_wr) begin
        port_mode_select <= wdata_i[3:0];
        port_enable <= wdata_i[`SSC_C1_EN];
        clock_release <= wdata_i[`SSC_C1_REL];
        overflow <= wdata_i[`SSC_C1_OVF] && overflow;
      end
      if (wr_i && addr_i == `SSC_OFF_ADDR) begin
        baud_or_address_value <= wdata_i;
      end
      if (hold_on && eighth_fall) begin
        clock_release <= 1'b0;
      end
      // Set wins over clear; host never flags overflow
      if (!is_host && byte_done && buf_full) begin
        overflow <= 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      general_call_enable <= 1'b0;
      ack_value_to_send <= 1'b0;
      ack_sequence_trigger <= 1'b0;
      host_receive_enable <= 1'b0;
      stop_trigger <= 1'b0;
      repeated_start_trigger <= 1'b0;
      start_trigger <= 1'b0;
    end else begin
      if (seq_wr) begin
        general_call_enable <= wdata_i[`SSC_SQ_GC];
        ack_value_to_send <= wdata_i[`SSC_SQ_ACK_VALUE_TO_SEND];
        if (!is_host) begin
          start_trigger <= wdata_i[`SSC_SQ_START];
        end
      end
      if (seq_wr && !active && is_host && port_enable) begin
        // One request at a time, no spooling
        ack_sequence_trigger <= wdata_i[`SSC_SQ_ACK_SEQUENCE_TRIGGER];
        host_receive_enable <= wdata_i[`SSC_SQ_HOST_RECEIVE_ENABLE];
        stop_trigger <= wdata_i[`SSC_SQ_STOP];
        repeated_start_trigger <= wdata_i[`SSC_SQ_RST];
        start_trigger <= wdata_i[`SSC_SQ_START];
      end else if (seq_done) begin
        // Sequencer is already idle here, so clear in its start priority
        if (start_trigger) begin
          start_trigger <= 1'b0;
        end else if (repeated_start_trigger) begin
          repeated_start_trigger <= 1'b0;
        end else if (stop_trigger) begin
          stop_trigger <= 1'b0;
        end else begin
          ack_sequence_trigger <= 1'b0;
          host_receive_enable <= 1'b0;
        end
      end
    end
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_window_flag <= 1'b0;
      stop_irq_enable <= 1'b0;
      start_irq_enable <= 1'b0;
      address_hold_enable <= 1'b0;
      data_hold_enable <= 1'b0;
    end else begin
      if (evt_wr) begin
        stop_irq_enable <= wdata_i[`SSC_EV_PIE];
        start_irq_enable <= wdata_i[`SSC_EV_SIE];
        address_hold_enable <= wdata_i[`SSC_EV_ADDRESS_HOLD_ENABLE];
        data_hold_enable <= wdata_i[`SSC_EV_DATA_HOLD_ENABLE];
      end
      if (hold_on && eighth_fall) begin
        ack_window_flag <= 1'b1;
      end else if (scl_rise && cbit == 4'd8) begin
        ack_window_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Client general-call ack and pin drive
  logic gc_ack;
  assign gc_ack = is_client && general_call_enable && cbit == 4'd8 &&
                  shreg == 8'h00;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_o <= '0;
      bus_oe_n_o <= '1;
      port_pins_owned_o <= 1'b0;
    end else begin
      port_pins_owned_o <= port_enable;
      bus_o <= '0;
      // Open drain: only low is driven
      bus_oe_n_o.scl <= !(port_enable && (is_host && !scl_drv ||
        is_client && (!clock_release || start_trigger && hold_on)));
      bus_oe_n_o.sda <= !(port_enable && (is_host && !sda_drv ||
        gc_ack));
    end
  end

  // ==========================================================
  // Read data
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= `SSC_RST_REG;
    end else if (rd_i) begin
      unique case (addr_i)
        `SSC_OFF_BUF: rdata_o <= shift_buffer;
        `SSC_OFF_ADDR: rdata_o <= baud_or_address_value;
        `SSC_OFF_STAT: rdata_o <= {5'h00, tx_busy, 1'b0, buf_full};
        `SSC_OFF_CTRL1: rdata_o <= {1'b0, overflow, port_enable,
                                    clock_release, port_mode_select};
        `SSC_OFF_SEQ: rdata_o <= {general_call_enable, ack_received_status,
          ack_value_to_send, ack_sequence_trigger, host_receive_enable,
          stop_trigger, repeated_start_trigger, start_trigger};
        `SSC_OFF_EVT: rdata_o <= {ack_window_flag, stop_irq_enable,
          start_irq_enable, 3'b000, address_hold_enable, data_hold_enable};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule

//--- ssc_core_properties.sv
`timescale 1ns/1ps
// ==========================================================
// Port-level properties of the serial port core
module ssc_core_properties (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire ssc_pkg::ssc_wire_t bus_i,
  input wire ssc_pkg::ssc_wire_t bus_o,
  input wire ssc_pkg::ssc_wire_t bus_oe_n_o,
  input wire logic port_pins_owned_o,
  input wire logic spi_clk_o,
  input wire logic start_event_o,
  input wire logic stop_event_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // Read data only stands in the cycle after the strobe
  a_read_data_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside read slot");
  a_start_one_cycle: assert property (
    start_event_o |=> !start_event_o)
    else $error("start event longer than one cycle");
  a_stop_one_cycle: assert property (
    stop_event_o |=> !stop_event_o)
    else $error("stop event longer than one cycle");
  a_start_sda_low: assert property (
    start_event_o |-> !bus_i.sda)
    else $error("start event with data line high");
  a_stop_lines_high: assert property (
    stop_event_o |-> bus_i.sda && bus_i.scl)
    else $error("stop event with a line low");
  // Two cycles of history, since owner flag and pins are both registered
  a_off_lines_free: assert property (
    !port_pins_owned_o && $past(port_pins_owned_o, 2) == 1'b0
      |-> bus_oe_n_o == 2'b11 && bus_o == 2'b00)
    else $error("bus pulled while port disabled");
  a_off_no_events: assert property (
    !port_pins_owned_o && $past(port_pins_owned_o, 2) == 1'b0
      |-> !start_event_o && !stop_event_o)
    else $error("event raised while port disabled");
  a_off_spi_still: assert property (
    !port_pins_owned_o && $past(port_pins_owned_o, 2) == 1'b0
      |-> $stable(spi_clk_o))
    else $error("serial clock moves while port disabled");
endmodule

bind ssc_core ssc_core_properties u_props (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .bus_i(bus_i),
  .bus_o(bus_o),
  .bus_oe_n_o(bus_oe_n_o),
  .port_pins_owned_o(port_pins_owned_o),
  .spi_clk_o(spi_clk_o),
  .start_event_o(start_event_o),
  .stop_event_o(stop_event_o)
);

//--- ssc_client_model.sv
`timescale 1ns/1ps
// ==========================================================
// Two-wire client on the far side of the bus
module ssc_client_model (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic ack_en_i,
  input wire logic send_i,
  input wire logic [7:0] tx_byte_i,
  output logic sda_pull_o
);
  int cnt = 0;
  int pos = 9;
  // Start or repeated start restarts the bit count
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      cnt = 0;
      pos = 9;
    end
  end
  // Stop releases the line until the next frame
  always @(posedge sda_i) begin
    if (scl_i === 1'b1) pos = 9;
  end
  always @(posedge scl_i) cnt = cnt + 1;
  // Own data only changes after a falling clock edge
  always @(negedge scl_i) begin
    if (cnt >= 9) cnt = 0;
    pos = cnt;
  end
  // Ack slot follows the eighth falling edge; a released line floats high
  assign sda_pull_o = (pos == 8 && ack_en_i && !send_i) ||
    (send_i && pos < 8 && !tx_byte_i[7 - pos]);
endmodule

//--- sync_serial_mode_and_i2c_control_tb.sv
`timescale 1ns/1ps
`include "ssc_consts.svh"
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
// ==========================================================
// Register-level bench
module sync_serial_mode_and_i2c_control_tb;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic tmr = 1'b0;
  logic sck = 1'b0;
  logic cs_n = 1'b0;
  logic scl_pull = 1'b0;
  ssc_pkg::ssc_wire_t bus_in, bus_out, bus_oe_n;
  logic owned, spi_clk, st_ev, sp_ev, sda_pull;
  logic ack_en = 1'b1;
  logic send = 1'b0;
  logic [7:0] tx_byte = 8'h5A;
  logic [7:0] rv;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int start_n = 0;
  int stop_n = 0;
  int pulled;
  int n;

  // Open-drain lines with pull-ups
  assign bus_in.scl = bus_oe_n.scl & ~scl_pull;
  assign bus_in.sda = bus_oe_n.sda & ~sda_pull;

  ssc_core i_dut (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .periodic_timer_output_i(tmr),
    .serial_clock_pin_i(sck),
    .client_select_pin_n_i(cs_n),
    .bus_i(bus_in),
    .bus_o(bus_out),
    .bus_oe_n_o(bus_oe_n),
    .port_pins_owned_o(owned),
    .spi_clk_o(spi_clk),
    .start_event_o(st_ev),
    .stop_event_o(sp_ev)
  );

  ssc_client_model i_client (
    .scl_i(bus_in.scl),
    .sda_i(bus_in.sda),
    .ack_en_i(ack_en),
    .send_i(send),
    .tx_byte_i(tx_byte),
    .sda_pull_o(sda_pull)
  );

  always #5 sys_clk_i = ~sys_clk_i;

  // Timer of period 6, external clock, event counts and hang limit
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc % 3 == 0) tmr <= ~tmr;
    if (cyc % 5 == 0) sck <= ~sck;
    if (st_ev === 1'b1) start_n++;
    if (sp_ev === 1'b1) stop_n++;
    if (cyc == 40000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    rd(a, rv);
    `CHK(rv, e)
  endtask

  // Poll until a bit clears, counting samples with the port itself pulling data low
  task automatic wait_clr(input logic [15:0] a, input int b);
    pulled = 0;
    for (int i = 0; i < 500; i++) begin
      rd(a, rv);
      if (bus_oe_n.sda === 1'b0) pulled++;
      if (rv[b] === 1'b0) break;
    end
  endtask

  // Period of the serial clock, measured between its 2nd and 3rd rise
  task automatic spi_period(input logic [3:0] m, input int e);
    logic prev;
    int edges;
    wr(`SSC_OFF_CTRL1, {4'h2, m});
    edges = 0;
    n = 0;
    prev = spi_clk;
    for (int i = 0; i < 600 && edges < 3; i++) begin
      @(posedge sys_clk_i);
      #1;
      n++;
      if (spi_clk === 1'b1 && prev === 1'b0) begin
        edges++;
        if (edges == 2) n = 0;
      end
      prev = spi_clk;
    end
    `CHK(n, e)
  endtask

  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rchk(`SSC_OFF_SEQ, `SSC_RST_REG);
    rchk(`SSC_OFF_EVT, `SSC_RST_REG);
    rchk(`SSC_OFF_CTRL1, `SSC_RST_REG);
    rchk(16'h0000, 8'h00);
    $display("test reset_values done");

    // Baud value kept above zero by software
    wr(`SSC_OFF_ADDR, 8'h01);
    wr(`SSC_OFF_EVT, 8'h60);
    wr(`SSC_OFF_CTRL1, 8'h28);
    @(posedge sys_clk_i);
    #1;
    `CHK(owned, 1'b1)
    wr(`SSC_OFF_SEQ, 8'h01);
    rchk(`SSC_OFF_SEQ, 8'h01);
    wait_clr(`SSC_OFF_SEQ, 0);
    `CHK(rv, 8'h00)
    `CHK(start_n, 1)
    wr(`SSC_OFF_BUF, 8'hA0);
    wr(`SSC_OFF_SEQ, 8'h04);
    rchk(`SSC_OFF_SEQ, 8'h00);
    wait_clr(`SSC_OFF_STAT, 2);
    rchk(`SSC_OFF_SEQ, 8'h00);
    $display("test host_start_address done");

    // Client drives the byte only once the address has passed
    send = 1'b1;
    wr(`SSC_OFF_SEQ, 8'h08);
    wait_clr(`SSC_OFF_SEQ, 3);
    `CHK(rv[3], 1'b0)
    rchk(`SSC_OFF_BUF, 8'h5A);
    rchk(`SSC_OFF_CTRL1, 8'h28);
    send = 1'b0;
    ack_en = 1'b0;
    wr(`SSC_OFF_SEQ, 8'h30);
    wait_clr(`SSC_OFF_SEQ, 4);
    `CHK(rv, 8'h20)
    `CHK(pulled, 0)
    tx_byte = 8'hC3;
    send = 1'b1;
    wr(`SSC_OFF_SEQ, 8'h08);
    wait_clr(`SSC_OFF_SEQ, 3);
    rchk(`SSC_OFF_BUF, 8'hC3);
    send = 1'b0;
    wr(`SSC_OFF_SEQ, 8'h10);
    wait_clr(`SSC_OFF_SEQ, 4);
    `CHK(rv[4], 1'b0)
    `CHK(pulled > 0, 1'b1)
    $display("test host_receive_ack done");

    wr(`SSC_OFF_SEQ, 8'h02);
    wait_clr(`SSC_OFF_SEQ, 1);
    `CHK(rv[1], 1'b0)
    `CHK(start_n, 2)
    wr(`SSC_OFF_BUF, 8'hA1);
    wait_clr(`SSC_OFF_STAT, 2);
    rchk(`SSC_OFF_SEQ, 8'h40);
    wr(`SSC_OFF_SEQ, 8'h04);
    wait_clr(`SSC_OFF_SEQ, 2);
    `CHK(rv[2], 1'b0)
    `CHK(stop_n, 1)
    `CHK(bus_in, 2'b11)
    $display("test restart_nack_stop done");

    // Events masked: no pulses for a full start and stop
    wr(`SSC_OFF_EVT, 8'h00);
    wr(`SSC_OFF_SEQ, 8'h01);
    wait_clr(`SSC_OFF_SEQ, 0);
    wr(`SSC_OFF_SEQ, 8'h04);
    wait_clr(`SSC_OFF_SEQ, 2);
    `CHK(start_n, 2)
    `CHK(stop_n, 1)
    $display("test events_masked done");

    // Reserved modes are never written
    spi_period(4'h0, 4);
    spi_period(4'h1, 16);
    spi_period(4'h2, 64);
    spi_period(4'h3, 12);
    spi_period(4'h5, 10);
    spi_period(4'h4, 10);
    // Deselected: no rising edge in the whole window
    cs_n <= 1'b1;
    spi_period(4'h4, 600);
    cs_n <= 1'b0;
    wr(`SSC_OFF_ADDR, 8'h02);
    spi_period(4'hA, 12);
    $display("test spi_clocks done");

    // Client with address hold: eight falls open the ack window
    wr(`SSC_OFF_EVT, 8'h02);
    wr(`SSC_OFF_CTRL1, 8'h36);
    wr(`SSC_OFF_BUF, 8'h00);
    wr(`SSC_OFF_SEQ, 8'h80);
    for (int i = 0; i < 8; i++) begin
      scl_pull <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      scl_pull <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
    end
    rchk(`SSC_OFF_EVT, 8'h82);
    rchk(`SSC_OFF_CTRL1, 8'h26);
    `CHK(bus_in.scl, 1'b0)
    `CHK(bus_in.sda, 1'b0)
    wr(`SSC_OFF_CTRL1, 8'h36);
    repeat (2) @(posedge sys_clk_i);
    rchk(`SSC_OFF_EVT, 8'h02);
    $display("test client_hold done");

    wr(`SSC_OFF_CTRL1, 8'h08);
    repeat (2) @(posedge sys_clk_i);
    `CHK(owned, 1'b0)
    wr(`SSC_OFF_SEQ, 8'h01);
    rd(`SSC_OFF_SEQ, rv);
    `CHK(rv[0], 1'b0)
    $display("test port_disabled done");
    end_of_test();
  end
endmodule
